// ### verilog/cpf_core.sv
`include "cpf_consts.svh"
module cpf_core #(
  parameter int PC_WIDTH = 12,
  parameter int STACK_DEPTH = 4
) (
  input wire logic mclk_i, // instruction cycle clock
  input wire logic rst_b_i, // any device reset, active low
  input wire cpf_pkg::cpf_instr_type instr_i, // decoded control op
  input wire cpf_pkg::cpf_data_req_type data_req_i, // data space access
  input wire logic [7:0] status_wdata_i, // status write value from core
  input wire logic [7:0] ext_rdata_i, // read data of the addressed file register
  input wire logic pin_dir_control_i, // direction setting of timer pin
  output logic [PC_WIDTH-1:0] pc_o, // program counter
  output logic [7:0] rdata_o, // data read result
  output logic [7:0] ext_addr_o, // effective file address
  output logic ext_wr_o, // write strobe to file register
  output logic [7:0] ext_wdata_o, // write data to file register
  output logic [7:0] wreg_load_o, // literal for working register
  output logic wreg_load_en_o, // working register load strobe
  output cpf_pkg::cpf_cfg_type cfg_o, // config fields
  output logic wake_enable_o, // pin-change wake-up enabled
  output logic pullup_enable_o, // weak pull-ups enabled
  output logic timer_use_ext_o, // timer counts pin transitions
  output logic timer_falling_o, // count falling edges
  output logic prescale_to_watchdog_o, // prescaler on watchdog
  output logic [8:0] timer_divide_o, // timer prescale divisor
  output logic [7:0] watchdog_divide_o, // watchdog prescale divisor
  output logic timer_pin_dir_o, // effective pin direction, 1 input
  output logic [1:0] page_preselect_o, // page preselect bits
  output logic [6:0] oscillator_trim_o // trim value to oscillator
);
  // ==========================================================
  // reset synchroniser
  // asserts at once, releases two clean edges later
  logic [1:0] rst_sync;
  logic rst_b;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  // ==========================================================
  // state
  typedef struct packed {
    logic [PC_WIDTH-1:0] pc;
    cpf_pkg::cpf_cfg_type cfg;
    logic [6:0] trim;
    logic [7:0] pointer;
    logic [7:0] status;
    logic [7:0] rdata;
    logic [7:0] ext_addr;
    logic ext_wr;
    logic [7:0] ext_wdata;
    logic [7:0] wreg_load;
    logic wreg_load_en;
    logic [8:0] tdiv;
    logic [7:0] wdiv;
    logic pin_dir;
    logic wake_en;
    logic pullup_en;
  } cpf_state_type;

  cpf_state_type st;
  cpf_state_type next_st;
  logic [PC_WIDTH-1:0] stack_top;
  logic [PC_WIDTH-1:0] pc_inc;
  logic do_push;
  logic do_pop;
  logic [7:0] eff_addr;
  logic pcl_data_write;
  logic null_access;

  // ==========================================================
  // helpers
  // power of two divisor
  function automatic logic [8:0] cpf_pow2(input logic [3:0] n);
    cpf_pow2 = 9'h001 << n;
  endfunction : cpf_pow2

  // page preselect field of a status value
  function automatic logic [1:0] cpf_page(input logic [7:0] status);
    cpf_page = status[`CPF_STATUS_PA_HI:`CPF_STATUS_PA_LO];
  endfunction : cpf_page

  // call and low byte write: top bit kept, bit 8 cleared, page from preselect
  function automatic logic [PC_WIDTH-1:0] cpf_near_target(
    input logic [PC_WIDTH-1:0] pc,
    input logic [7:0] status,
    input logic [7:0] low
  );
    cpf_near_target = pc;
    cpf_near_target[7:0] = low;
    cpf_near_target[8] = 1'b0;
    cpf_near_target[10:9] = cpf_page(status);
  endfunction : cpf_near_target

  // jump: nine bits from the instruction, top bit cleared
  function automatic logic [PC_WIDTH-1:0] cpf_far_target(
    input logic [7:0] status,
    input logic [8:0] imm
  );
    cpf_far_target = '0;
    cpf_far_target[8:0] = imm;
    cpf_far_target[10:9] = cpf_page(status);
  endfunction : cpf_far_target

  // indirect port with a zero pointer
  function automatic logic cpf_null_access(
    input logic [7:0] addr,
    input logic [7:0] pointer
  );
    cpf_null_access = (addr == `CPF_ADDR_INDIRECT) && (pointer == 8'h00);
  endfunction : cpf_null_access

  // core-held register value, or the file data for any other address
  function automatic logic [7:0] cpf_read_mux(
    input logic [7:0] addr,
    input logic [PC_WIDTH-1:0] pc,
    input logic [7:0] status,
    input logic [7:0] pointer,
    input logic [6:0] trim,
    input logic [7:0] file_data
  );
    unique case (addr)
      `CPF_ADDR_PC_LOW: cpf_read_mux = pc[7:0];
      `CPF_ADDR_STATUS: cpf_read_mux = status;
      `CPF_ADDR_POINTER: cpf_read_mux = pointer;
      `CPF_ADDR_TRIM: cpf_read_mux = {trim, 1'b0};
      default: cpf_read_mux = file_data;
    endcase
  endfunction : cpf_read_mux

  // ==========================================================
  // addressing
  assign pc_inc = st.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  assign do_push = (instr_i.op == cpf_pkg::CPF_OP_CALL);
  assign do_pop = (instr_i.op == cpf_pkg::CPF_OP_RETURN);
  // indirect port resolves through the pointer
  assign eff_addr = (data_req_i.addr == `CPF_ADDR_INDIRECT) ? st.pointer :
                    data_req_i.addr;
  assign pcl_data_write = data_req_i.wr && (eff_addr == `CPF_ADDR_PC_LOW);
  assign null_access = cpf_null_access(data_req_i.addr, st.pointer);

  // ==========================================================
  // return stack
  cpf_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_WIDTH)
  ) u_stack (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b),
    .push_i(do_push),
    .pop_i(do_pop),
    .push_addr_i(pc_inc),
    .top_o(stack_top)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.ext_wr = 1'b0;
    next_st.wreg_load_en = 1'b0;
    next_st.pc = pc_inc;
    unique case (instr_i.op)
      cpf_pkg::CPF_OP_SEQ: begin
      end
      cpf_pkg::CPF_OP_JUMP: begin
        next_st.pc = cpf_far_target(st.status, instr_i.imm);
      end
      cpf_pkg::CPF_OP_CALL: begin
        next_st.pc = cpf_near_target(st.pc, st.status, instr_i.imm[7:0]);
      end
      cpf_pkg::CPF_OP_RETURN: begin
        next_st.pc = stack_top;
        next_st.wreg_load = instr_i.imm[7:0];
        next_st.wreg_load_en = 1'b1;
      end
      cpf_pkg::CPF_OP_PCL_WRITE: begin
        next_st.pc = st.pc;
      end
      cpf_pkg::CPF_OP_OPTION: begin
        next_st.cfg = cpf_pkg::cpf_cfg_type'(instr_i.wreg);
      end
      cpf_pkg::CPF_OP_HOLD: begin
        next_st.pc = st.pc;
      end
      default: begin
        next_st.pc = st.pc;
      end
    endcase
    // computed jump through the low byte
    if (pcl_data_write) begin
      next_st.pc = cpf_near_target(st.pc, st.status, data_req_i.wdata);
    end
    // data space reads
    next_st.rdata = 8'h00;
    if (data_req_i.rd) begin
      if (null_access) begin
        next_st.rdata = 8'h00;
      end else begin
        next_st.rdata = cpf_read_mux(eff_addr, st.pc, st.status, st.pointer, st.trim,
                                     ext_rdata_i);
      end
    end
    // data space writes; pointer zero through indirect port is dropped
    if (data_req_i.wr && !null_access) begin
      unique case (eff_addr)
        `CPF_ADDR_PC_LOW: begin
        end
        `CPF_ADDR_STATUS: next_st.status = status_wdata_i;
        `CPF_ADDR_POINTER: next_st.pointer = data_req_i.wdata;
        `CPF_ADDR_TRIM: next_st.trim = data_req_i.wdata[7:1];
        default: begin
          next_st.ext_wr = 1'b1;
          next_st.ext_wdata = data_req_i.wdata;
        end
      endcase
    end
    next_st.ext_addr = eff_addr;
    next_st.tdiv = cpf_pow2({1'b0, next_st.cfg.prescale_ratio} + 4'h1);
    next_st.wdiv = 8'(cpf_pow2({1'b0, next_st.cfg.prescale_ratio}));
    next_st.pin_dir = next_st.cfg.timer_source_select | pin_dir_control_i;
    // enables are active high, the config bits disable
    next_st.wake_en = !next_st.cfg.pin_change_wake_disable;
    next_st.pullup_en = !next_st.cfg.weak_pullup_disable;
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      st.pc <= `CPF_PC_RESET;
      st.cfg <= `CPF_CFG_RESET;
      st.trim <= `CPF_TRIM_RESET;
      st.pointer <= `CPF_POINTER_RESET;
      st.status <= `CPF_STATUS_RESET;
      st.rdata <= 8'h00;
      st.ext_addr <= 8'h00;
      st.ext_wr <= 1'b0;
      st.ext_wdata <= 8'h00;
      st.wreg_load <= 8'h00;
      st.wreg_load_en <= 1'b0;
      st.tdiv <= `CPF_TDIV_RESET;
      st.wdiv <= `CPF_WDIV_RESET;
      st.pin_dir <= 1'b1;
      st.wake_en <= 1'b0;
      st.pullup_en <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign pc_o = st.pc;
  assign rdata_o = st.rdata;
  assign ext_addr_o = st.ext_addr;
  assign ext_wr_o = st.ext_wr;
  assign ext_wdata_o = st.ext_wdata;
  assign wreg_load_o = st.wreg_load;
  assign wreg_load_en_o = st.wreg_load_en;
  assign cfg_o = st.cfg;
  assign wake_enable_o = st.wake_en;
  assign pullup_enable_o = st.pullup_en;
  assign timer_use_ext_o = st.cfg.timer_source_select;
  assign timer_falling_o = st.cfg.timer_edge_select;
  assign prescale_to_watchdog_o = st.cfg.prescaler_assign;
  assign timer_divide_o = st.tdiv;
  assign watchdog_divide_o = st.wdiv;
  assign timer_pin_dir_o = st.pin_dir;
  assign page_preselect_o = st.status[`CPF_STATUS_PA_HI:`CPF_STATUS_PA_LO];
  assign oscillator_trim_o = st.trim;
endmodule : cpf_core

// ### inc/cpf_consts.svh
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH
// data register space addresses
`define CPF_ADDR_INDIRECT 8'h00
`define CPF_ADDR_PC_LOW 8'h02
`define CPF_ADDR_STATUS 8'h03
`define CPF_ADDR_POINTER 8'h04
`define CPF_ADDR_TRIM 8'h05
// config field positions
`define CPF_CFG_WAKE_BIT 7
`define CPF_CFG_PULLUP_BIT 6
`define CPF_CFG_SRC_BIT 5
`define CPF_CFG_EDGE_BIT 4
`define CPF_CFG_ASSIGN_BIT 3
// status page preselect positions
`define CPF_STATUS_PA_LO 5
`define CPF_STATUS_PA_HI 6
// reset values
`define CPF_CFG_RESET 8'hff
`define CPF_TRIM_RESET 7'h7f
`define CPF_PC_RESET 12'hfff
`define CPF_POINTER_RESET 8'h00
`define CPF_STATUS_RESET 8'h18
`define CPF_TDIV_RESET 9'h100
`define CPF_WDIV_RESET 8'h80
`endif

// ### inc/cpf_pkg.sv
package cpf_pkg;
  typedef enum logic [2:0] {
    CPF_OP_SEQ = 3'b000,
    CPF_OP_JUMP = 3'b001,
    CPF_OP_CALL = 3'b010,
    CPF_OP_RETURN = 3'b011,
    CPF_OP_PCL_WRITE = 3'b100,
    CPF_OP_OPTION = 3'b101,
    CPF_OP_HOLD = 3'b110
  } cpf_op_type;

  typedef struct packed {
    cpf_op_type op;
    logic [8:0] imm;
    logic [7:0] wreg;
  } cpf_instr_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpf_data_req_type;

  typedef struct packed {
    logic pin_change_wake_disable;
    logic weak_pullup_disable;
    logic timer_source_select;
    logic timer_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } cpf_cfg_type;
endpackage : cpf_pkg

// ### verilog/cpf_return_stack.sv
`include "cpf_consts.svh"
// four level return address stack, no overflow or underflow flags
module cpf_return_stack #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 12
) (
  input wire logic mclk_i, // clock
  input wire logic rst_b_i, // synchronised reset, active low
  input wire logic push_i, // call
  input wire logic pop_i, // return
  input wire logic [WIDTH-1:0] push_addr_i, // return address
  output logic [WIDTH-1:0] top_o // level one, no full or empty flag
);
  logic [WIDTH-1:0] level [DEPTH];
  logic [WIDTH-1:0] next_level [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_level[i] = level[i];
    end
    if (push_i) begin
      next_level[0] = push_addr_i;
      for (int i = 1; i < DEPTH; i++) begin
        next_level[i] = level[i-1];
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_level[i] = level[i+1];
      end
    end
  end

  // deepest level keeps its value on pop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        level[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        level[i] <= next_level[i];
      end
    end
  end

  assign top_o = level[0];
endmodule : cpf_return_stack

// ### tb/cpf_core_asserts.sv
// =========
// checker
module cpf_core_asserts #(
  parameter int PC_WIDTH = 12
) (
  input wire logic mclk_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire cpf_pkg::cpf_instr_type instr_i, // op
  input wire cpf_pkg::cpf_data_req_type data_req_i, // access
  input wire logic pin_dir_control_i, // pin direction setting
  input wire logic [PC_WIDTH-1:0] pc_o, // counter
  input wire logic [7:0] rdata_o, // read data
  input wire logic [7:0] wreg_load_o, // literal
  input wire logic wreg_load_en_o, // literal strobe
  input wire cpf_pkg::cpf_cfg_type cfg_o, // config
  input wire logic wake_enable_o, // wake
  input wire logic pullup_enable_o, // pull-ups
  input wire logic timer_use_ext_o, // source
  input wire logic timer_falling_o, // edge
  input wire logic prescale_to_watchdog_o, // assign
  input wire logic [8:0] timer_divide_o, // timer divisor
  input wire logic [7:0] watchdog_divide_o, // watchdog divisor
  input wire logic timer_pin_dir_o, // effective pin direction
  input wire logic [1:0] page_preselect_o, // page
  input wire logic [6:0] oscillator_trim_o // trim
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up;
  wire [2:0] op = instr_i.op;
  wire nw = !data_req_i.wr;
  wire run = up == 2'h3;
  // design leaves reset two edges after release
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_values: assert property (
    !run |-> pc_o == '1 && cfg_o == 8'hff && page_preselect_o == 2'h0 &&
    oscillator_trim_o == 7'h7f)
    else $error("reset values wrong");
  a_seq_advance: assert property (
    run && $past(op == 3'h0 && nw) |-> pc_o == $past(pc_o) + 1'b1)
    else $error("counter did not advance");
  a_jump_target: assert property (
    run && $past(op == 3'h1 && nw) |->
    pc_o == {1'b0, $past(page_preselect_o), $past(instr_i.imm)})
    else $error("jump target wrong");
  a_call_target: assert property (
    run && $past(op == 3'h2 && nw) |-> pc_o ==
    {$past(pc_o[PC_WIDTH-1]), $past(page_preselect_o), 1'b0, $past(instr_i.imm[7:0])})
    else $error("call target wrong");
  a_return_literal: assert property (
    run |-> wreg_load_en_o == $past(op == 3'h3) &&
    (!wreg_load_en_o || wreg_load_o == $past(instr_i.imm[7:0])))
    else $error("literal load wrong");
  a_option_load: assert property (
    run && $past(op == 3'h5) |-> cfg_o == $past(instr_i.wreg))
    else $error("config not loaded");
  a_option_stable: assert property (
    run && $past(op != 3'h5) |-> $stable(cfg_o))
    else $error("config changed");
  a_trim_read: assert property (
    run && $past(data_req_i.rd && data_req_i.addr == 8'h05) |->
    rdata_o == {$past(oscillator_trim_o), 1'b0})
    else $error("trim read wrong");
  a_prescale_div: assert property (
    timer_divide_o == (9'h2 << cfg_o.prescale_ratio) &&
    watchdog_divide_o == (8'h1 << cfg_o.prescale_ratio))
    else $error("divisor wrong");
  a_cfg_decode: assert property (
    {wake_enable_o, pullup_enable_o, timer_use_ext_o, timer_falling_o,
    prescale_to_watchdog_o} == {~cfg_o[7:6], cfg_o[5:3]})
    else $error("config decode wrong");
  a_pin_dir: assert property (
    run |-> timer_pin_dir_o == (cfg_o.timer_source_select | $past(pin_dir_control_i)))
    else $error("pin direction wrong");
endmodule : cpf_core_asserts

bind cpf_core cpf_core_asserts #(.PC_WIDTH(PC_WIDTH)) i_cpf_core_asserts (.mclk_i, .rst_b_i,
  .instr_i, .data_req_i, .pc_o, .rdata_o, .wreg_load_o, .wreg_load_en_o, .cfg_o,
  .wake_enable_o, .pullup_enable_o, .timer_use_ext_o, .timer_falling_o,
  .prescale_to_watchdog_o, .timer_divide_o, .watchdog_divide_o, .page_preselect_o,
  .oscillator_trim_o, .pin_dir_control_i, .timer_pin_dir_o);

// ### tb/cpf_file_model.sv
// =========
// file registers behind the core
module cpf_file_model (
  input wire logic mclk_i, // clock
  input wire logic [7:0] addr_i, // file address
  input wire logic wr_i, // write strobe
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  // unwritten cells hold a pattern, never zero at address 00
  initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
  always @(posedge mclk_i) if (wr_i) mem[addr_i] <= wdata_i;
  assign rdata_o = mem[addr_i];
endmodule : cpf_file_model

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] op;
    logic [8:0] imm;
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [11:0] pc;
  } cpf_row_type;
  logic mclk_i, rst_b_i, dir, ew, wle, pdir;
  cpf_pkg::cpf_instr_type instr;
  cpf_pkg::cpf_data_req_type req;
  cpf_pkg::cpf_cfg_type cfg;
  logic [7:0] st_wd, ext_rd, rd, ea, ewd, wl;
  logic [11:0] pc;
  logic [8:0] tdiv;
  logic [1:0] pg;
  logic [6:0] trim;
  int err_count, compares;
  cpf_row_type rows [9];
  cpf_core i_cpf_core (.mclk_i, .rst_b_i, .instr_i(instr), .data_req_i(req),
    .status_wdata_i(st_wd), .ext_rdata_i(ext_rd), .pin_dir_control_i(dir), .pc_o(pc),
    .rdata_o(rd), .ext_addr_o(ea), .ext_wr_o(ew), .ext_wdata_o(ewd), .wreg_load_o(wl),
    .wreg_load_en_o(wle), .cfg_o(cfg), .wake_enable_o(), .pullup_enable_o(),
    .timer_use_ext_o(), .timer_falling_o(), .prescale_to_watchdog_o(),
    .timer_divide_o(tdiv), .watchdog_divide_o(), .timer_pin_dir_o(pdir),
    .page_preselect_o(pg), .oscillator_trim_o(trim));
  cpf_file_model i_cpf_file_model (.mclk_i, .addr_i(ea), .wr_i(ew), .wdata_i(ewd),
    .rdata_o(ext_rd));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // =========
  // tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input logic [2:0] op, input logic [8:0] imm, input logic [7:0] w,
      input logic wr, input logic rdq, input logic [7:0] a, input logic [7:0] d);
    instr = '{cpf_pkg::cpf_op_type'(op), imm, w};
    req = '{wr, rdq, a, d};
    @(posedge mclk_i);
    #1;
  endtask : step
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  // =========
  // tests
  initial begin
    rst_b_i = 1'b0;
    instr = '0;
    req = '0;
    st_wd = 8'h00;
    dir = 1'b0;
    rows = '{'{3'h0, 9'h000, 1'b0, 8'h00, 8'h00, 12'h000},
      '{3'h0, 9'h000, 1'b0, 8'h00, 8'h00, 12'h001},
      '{3'h1, 9'h1a5, 1'b0, 8'h00, 8'h00, 12'h1a5},
      '{3'h2, 9'h1c3, 1'b0, 8'h00, 8'h00, 12'h0c3},
      '{3'h2, 9'h010, 1'b0, 8'h00, 8'h00, 12'h010},
      '{3'h3, 9'h055, 1'b0, 8'h00, 8'h00, 12'h0c4},
      '{3'h3, 9'h066, 1'b0, 8'h00, 8'h00, 12'h1a6},
      '{3'h0, 9'h000, 1'b1, 8'h02, 8'h77, 12'h077},
      '{3'h5, 9'h000, 1'b0, 8'h00, 8'h00, 12'h078}};
    repeat (12) @(posedge mclk_i);
    #1;
    chk(pc, 12'hfff);
    chk(cfg, 8'hff);
    chk({pg, trim}, 9'h07f);
    chk({pdir, tdiv}, 10'h300);
    $display("test reset done");
    rst_b_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].imm, 8'h5a, rows[i].wr, 1'b0, rows[i].a, rows[i].d);
      chk(pc, rows[i].pc);
      if (rows[i].op == 3'h3) chk(wl, rows[i].imm[7:0]);
    end
    chk(cfg, 8'h5a);
    chk({pdir, tdiv}, 10'h008);
    step(3'h5, 9'h000, 8'h24, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({pdir, tdiv}, 10'h220);
    dir = 1'b1;
    step(3'h5, 9'h000, 8'h1f, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({pdir, tdiv}, 10'h300);
    $display("test table done");
    st_wd = 8'h20;
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h03, 8'h00);
    chk(pg, 2'h1);
    step(3'h1, 9'h0f0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(pc, 12'h2f0);
    for (int i = 1; i < 6; i++) begin
      step(3'h2, 9'(i), 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(pc, 12'h200 + 12'(i));
    end
    // fifth call dropped the oldest level, then underflow repeats
    for (int i = 0; i < 5; i++) begin
      step(3'h3, 9'h0a0 + 9'(i), 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(pc, 12'h205 - 12'(i < 3 ? i : 3));
    end
    $display("test stack done");
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h05, 8'h81);
    step(3'h0, 9'h000, 8'h00, 1'b0, 1'b1, 8'h05, 8'h00);
    chk(rd, 8'h80);
    chk(trim, 7'h40);
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h04, 8'h00);
    step(3'h0, 9'h000, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00);
    chk(rd, 8'h00);
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h99);
    chk(ew, 1'b0);
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h04, 8'h10);
    step(3'h0, 9'h000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h3c);
    chk({ew, ea}, 9'h110);
    step(3'h0, 9'h000, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(i_cpf_file_model.mem[8'h10], 8'h3c);
    $display("test trim and pointer done");
    rst_b_i = 1'b0;
    #40;
    chk({cfg, pg}, 10'h3fc);
    $display("test second reset done");
    close_out();
  end
endmodule : tb_top
